// ### hdl/twct_target.sv
/*
 Two-wire configuration target: address match, register index and
 auto-incrementing pointer, register access handed to the system side.
 Assumes clk_link_i is the free-running crystal and the config registers
 answer cfg_rdata_i combinationally from cfg_addr_o.
*/
// Notes on behaviour
// - Both lines high means bus idle
// - Host starts: SDA falls while SCL high
// - Ignore everything until a start is seen
// - Host sends seven address bits, then direction
// - Acknowledge own address, stay silent otherwise
// - One or more bytes follow the acknowledge
// - SDA rising with SCL high ends transfer
// - Repeated start begins a new address phase
// - SDA changes only while SCL low
// - Sample on delayed rising SCL edge
// - Filter and delay lines three crystal periods
// - Read data changes after delayed falling edge
// - Address byte compared with address pins
// - First write byte sets register index
// - Pointer advances after each written byte
// - Pointer advances after each read byte
// - Own address comes only from pins
`timescale 1ns/1ps
module twct_target
	import twct_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              rst_n_i,
	input  wire logic              clk_link_i,
	twct_link_if.target            bus,
	input  wire logic [ADDR_W-1:0] dev_addr_i,
	output logic                   cfg_wr_o,
	output logic                   cfg_rd_o,
	output logic [DATA_W-1:0]      cfg_addr_o,
	output logic [DATA_W-1:0]      cfg_wdata_o,
	input  wire logic [DATA_W-1:0] cfg_rdata_i
);

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RECV = 5'h02,
		ST_ACK  = 5'h04,
		ST_SEND = 5'h08,
		ST_RACK = 5'h10
	} twct_tst_t;

	typedef enum logic [2:0] {
		K_ADDR  = 3'h1,
		K_INDEX = 3'h2,
		K_DATA  = 3'h4
	} twct_kind_t;

	logic [2:0]        rst_l_q;
	logic              rst_l_n;
	logic [1:0]        line_raw;
	logic [1:0]        line_f;
	logic              scl_f;
	logic              sda_f;
	logic              scl_p_q;
	logic              sda_p_q;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_ev;
	logic              stop_ev;
	logic [ADDR_W-1:0] a_s0_q;
	logic [ADDR_W-1:0] a_s1_q;
	logic [ADDR_W-1:0] a_s2_q;
	logic [ADDR_W-1:0] addr_q;
	twct_tst_t         state_q;
	twct_kind_t        kind_q;
	logic [3:0]        cnt_q;
	logic [DATA_W-1:0] shreg_q;
	logic              rw_q;
	logic              oe_q;
	logic              addr_match;
	logic              byte_done;
	logic              idx_done;
	logic              wr_done;
	logic              rd_first;
	logic              rd_next;
	logic [DATA_W-1:0] ptr_q;
	logic              req_tgl_q;
	logic              req_wr_q;
	logic [DATA_W-1:0] req_addr_q;
	logic [DATA_W-1:0] req_wdata_q;
	logic [2:0]        ack_s_q;
	logic [DATA_W-1:0] rdata_q;
	logic [2:0]        req_s_q;
	logic              ack_tgl_q;
	logic [DATA_W-1:0] rdata_sys_q;

	// Link-domain reset follows the system reset
	always_ff @(posedge clk_link_i) begin
		rst_l_q <= {rst_l_q[1:0], rst_n_i};
	end
	assign rst_l_n = rst_l_q[2];

	// Same sync and filter on both lines keeps them aligned
	assign line_raw = {bus.sda, bus.scl};
	for (genvar i = 0; i < 2; i++) begin : g_line
		logic [2:0] sy_q;
		logic [1:0] fc_q;
		logic       f_q;
		always_ff @(posedge clk_link_i) begin
			if (!rst_l_n) begin
				sy_q <= SYNC_RST;
				fc_q <= 2'h0;
				f_q  <= 1'b1;
			end else begin
				sy_q <= {sy_q[1:0], line_raw[i]};
				if (sy_q[1] != sy_q[2] || sy_q[2] == f_q) begin
					fc_q <= 2'h0;
				end else if (fc_q == FILT_CNT_MAX) begin
					fc_q <= 2'h0;
					f_q  <= sy_q[2];
				end else begin
					fc_q <= fc_q + 2'h1;
				end
			end
		end
		assign line_f[i] = f_q;
	end
	assign scl_f = line_f[0];
	assign sda_f = line_f[1];

	always_ff @(posedge clk_link_i) begin
		if (!rst_l_n) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_p_q;
	assign scl_fall = ~scl_f & scl_p_q;
	assign start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
	assign stop_ev  = scl_f & scl_p_q & ~sda_p_q & sda_f;

	// Address pins are straps; a change counts once stages agree
	always_ff @(posedge clk_link_i) begin
		a_s0_q <= dev_addr_i;
		a_s1_q <= a_s0_q;
		a_s2_q <= a_s1_q;
		if (!rst_l_n) begin
			addr_q <= '0;
		end else if (a_s1_q == a_s2_q) begin
			addr_q <= a_s2_q;
		end
	end

	assign addr_match = (shreg_q[DATA_W-1:1] == addr_q);
	assign byte_done  = (state_q == ST_RECV) && scl_fall &&
		(cnt_q == BITS_PER_BYTE);
	assign idx_done   = byte_done && (kind_q == K_INDEX);
	assign wr_done    = byte_done && (kind_q == K_DATA);
	assign rd_first   = byte_done && (kind_q == K_ADDR) && addr_match &&
		shreg_q[0];
	assign rd_next    = (state_q == ST_SEND) && scl_fall &&
		(cnt_q == BITS_PER_BYTE);

	// Bit engine; SDA only ever released or pulled low
	always_ff @(posedge clk_link_i) begin
		if (!rst_l_n) begin
			state_q <= ST_IDLE;
			kind_q  <= K_ADDR;
			cnt_q   <= 4'h0;
			shreg_q <= '0;
			rw_q    <= 1'b0;
			oe_q    <= 1'b0;
		end else if (start_ev) begin
			state_q <= ST_RECV;
			kind_q  <= K_ADDR;
			cnt_q   <= 4'h0;
			oe_q    <= 1'b0;
		end else if (stop_ev) begin
			state_q <= ST_IDLE;
			oe_q    <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				oe_q <= 1'b0;
			end
			ST_RECV: begin
				if (scl_rise) begin
					shreg_q <= {shreg_q[DATA_W-2:0], sda_f};
					cnt_q   <= cnt_q + 4'h1;
				end else if (byte_done) begin
					if (kind_q == K_ADDR && !addr_match) begin
						state_q <= ST_IDLE;
					end else begin
						state_q <= ST_ACK;
						oe_q    <= 1'b1;
						if (kind_q == K_ADDR) begin
							rw_q <= shreg_q[0];
						end
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					cnt_q <= 4'h0;
					if (kind_q == K_ADDR && rw_q) begin
						state_q <= ST_SEND;
						shreg_q <= rdata_q;
						oe_q    <= ~rdata_q[DATA_W-1];
					end else begin
						state_q <= ST_RECV;
						oe_q    <= 1'b0;
						kind_q  <= (kind_q == K_ADDR) ? K_INDEX : K_DATA;
					end
				end
			end
			ST_SEND: begin
				if (scl_rise) begin
					cnt_q <= cnt_q + 4'h1;
				end else if (rd_next) begin
					state_q <= ST_RACK;
					oe_q    <= 1'b0;
				end else if (scl_fall) begin
					shreg_q <= {shreg_q[DATA_W-2:0], 1'b0};
					oe_q    <= ~shreg_q[DATA_W-2];
				end
			end
			ST_RACK: begin
				if (scl_rise && sda_f) begin
					state_q <= ST_IDLE; // Host refused more data
				end else if (scl_fall) begin
					state_q <= ST_SEND;
					cnt_q   <= 4'h0;
					shreg_q <= rdata_q;
					oe_q    <= ~rdata_q[DATA_W-1];
				end
			end
			default: begin
				state_q <= ST_IDLE;
				oe_q    <= 1'b0;
			end
			endcase
		end
	end

	assign bus.sda_d_o  = 1'b0;
	assign bus.sda_d_oe = oe_q;

	// Pointer and register requests; one in flight, spaced by a byte
	always_ff @(posedge clk_link_i) begin
		if (!rst_l_n) begin
			ptr_q       <= PTR_RST;
			req_tgl_q   <= 1'b0;
			req_wr_q    <= 1'b0;
			req_addr_q  <= PTR_RST;
			req_wdata_q <= '0;
		end else if (idx_done) begin
			ptr_q <= shreg_q;
		end else if (wr_done) begin
			ptr_q       <= ptr_q + PTR_INC;
			req_tgl_q   <= ~req_tgl_q;
			req_wr_q    <= 1'b1;
			req_addr_q  <= ptr_q;
			req_wdata_q <= shreg_q;
		end else if (rd_first) begin
			req_tgl_q  <= ~req_tgl_q;
			req_wr_q   <= 1'b0;
			req_addr_q <= ptr_q;
		end else if (rd_next) begin
			// Prefetch so data is ready at the next falling edge
			ptr_q      <= ptr_q + PTR_INC;
			req_tgl_q  <= ~req_tgl_q;
			req_wr_q   <= 1'b0;
			req_addr_q <= ptr_q + PTR_INC;
		end
	end

	// Read data returns by toggle; held word is stable by then
	always_ff @(posedge clk_link_i) begin
		if (!rst_l_n) begin
			ack_s_q <= 3'h0;
			rdata_q <= '0;
		end else begin
			ack_s_q <= {ack_s_q[1:0], ack_tgl_q};
			if (ack_s_q[1] ^ ack_s_q[2]) begin
				rdata_q <= rdata_sys_q;
			end
		end
	end

	// System side: strobe the register file
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			req_s_q     <= 3'h0;
			cfg_wr_o    <= 1'b0;
			cfg_rd_o    <= 1'b0;
			cfg_addr_o  <= PTR_RST;
			cfg_wdata_o <= '0;
			ack_tgl_q   <= 1'b0;
			rdata_sys_q <= '0;
		end else begin
			req_s_q  <= {req_s_q[1:0], req_tgl_q};
			cfg_wr_o <= 1'b0;
			cfg_rd_o <= 1'b0;
			if (req_s_q[1] ^ req_s_q[2]) begin
				cfg_addr_o  <= req_addr_q;
				cfg_wdata_o <= req_wdata_q;
				cfg_wr_o    <= req_wr_q;
				cfg_rd_o    <= ~req_wr_q;
			end
			if (cfg_rd_o) begin
				rdata_sys_q <= cfg_rdata_i;
				ack_tgl_q   <= ~ack_tgl_q;
			end
		end
	end

endmodule

// ### shared/twct_pkg.sv
/*
 Constants shared by both ends of the two-wire configuration link.
 Assumes a 40 MHz system clock; the crystal figure is the target's own.
*/
package twct_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] PTR_INC = 8'h01;
	localparam logic [2:0] SYNC_RST = 3'h7;

	// Line filter: three crystal periods
	localparam int XTAL_PERIOD_NS = 40;
	localparam int FILT_NS        = 120;
	localparam int FILT_CYC       =
		(FILT_NS + XTAL_PERIOD_NS - 1) / XTAL_PERIOD_NS;
	localparam logic [1:0] FILT_CNT_MAX = 2'(FILT_CYC - 1);

	// Host bit timing: one quarter of an SCL period
	localparam int SYS_PERIOD_NS = 25;
	localparam int QTR_NS        = 1250;
	localparam int QTR_CYC       =
		(QTR_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [5:0] QTR_MAX = 6'(QTR_CYC - 1);

	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ  = 2'h2,
		OP_STOP  = 2'h3
	} twct_op_t;

endpackage

// ### shared/twct_link_if.sv
/*
 Two-wire link between host and target.
 Assumes an external pull-up: SDA is high unless an end pulls it low.
*/
`timescale 1ns/1ps
interface twct_link_if;
	logic scl;
	logic sda;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;

	// Wired-AND of both open-drain drivers
	assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

	modport host (
		output scl,
		output sda_h_o,
		output sda_h_oe,
		input  sda
	);
	modport target (
		input  scl,
		input  sda,
		output sda_d_o,
		output sda_d_oe
	);
endinterface

// ### hdl/twct_host.sv
/*
 Two-wire host: runs start, byte write, byte read and stop commands.
 Assumes the target answers within one quarter of an SCL period.
*/
`timescale 1ns/1ps
module twct_host
	import twct_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              rst_n_i,
	twct_link_if.host              bus,
	input  wire logic              cmd_valid_i,
	output logic                   cmd_ready_o,
	input  wire twct_op_t          cmd_op_i,
	input  wire logic [DATA_W-1:0] cmd_data_i,
	input  wire logic              cmd_nack_i,
	output logic                   rsp_valid_o,
	output logic [DATA_W-1:0]      rsp_data_o,
	output logic                   rsp_nack_o,
	output logic                   busy_o
);

	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_START = 4'h2,
		H_BYTE  = 4'h4,
		H_STOP  = 4'h8
	} twct_hst_t;

	twct_hst_t         state_q;
	logic [5:0]        qcnt_q;
	logic              tick;
	logic [1:0]        ph_q;
	logic [3:0]        bit_q;
	logic              scl_q;
	logic              oe_q;
	logic              rd_q;
	logic              nack_q;
	logic              ack_in_q;
	logic [DATA_W-1:0] sh_q;
	logic [2:0]        sy_q;
	logic              sda_in_q;

	assign cmd_ready_o = (state_q == H_IDLE);
	assign busy_o      = ~cmd_ready_o;
	assign tick        = (qcnt_q == QTR_MAX);

	// SCL is divided down from the system clock
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || state_q == H_IDLE || tick) begin
			qcnt_q <= 6'h0;
		end else begin
			qcnt_q <= qcnt_q + 6'h1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sy_q     <= SYNC_RST;
			sda_in_q <= 1'b1;
		end else begin
			sy_q <= {sy_q[1:0], bus.sda};
			if (sy_q[1] == sy_q[2]) begin
				sda_in_q <= sy_q[2];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_q     <= H_IDLE;
			ph_q        <= 2'h0;
			bit_q       <= 4'h0;
			scl_q       <= 1'b1;
			oe_q        <= 1'b0;
			rd_q        <= 1'b0;
			nack_q      <= 1'b0;
			ack_in_q    <= 1'b0;
			sh_q        <= '0;
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= '0;
			rsp_nack_o  <= 1'b0;
		end else begin
			rsp_valid_o <= 1'b0;
			case (state_q)
			H_IDLE: begin
				ph_q  <= 2'h0;
				bit_q <= 4'h0;
				if (cmd_valid_i) begin
					rd_q   <= (cmd_op_i == OP_READ);
					nack_q <= cmd_nack_i;
					sh_q   <= cmd_data_i;
					case (cmd_op_i)
					OP_START: state_q <= H_START;
					OP_STOP:  state_q <= H_STOP;
					default:  state_q <= H_BYTE;
					endcase
				end
			end
			H_START: begin
				// Works from idle and as a repeated start
				if (tick) begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
					2'h0: oe_q <= 1'b0;
					2'h1: scl_q <= 1'b1;
					2'h2: oe_q <= 1'b1;
					default: begin
						scl_q   <= 1'b0;
						state_q <= H_IDLE;
					end
					endcase
				end
			end
			H_STOP: begin
				if (tick) begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
					2'h0: oe_q <= 1'b1;
					2'h1: scl_q <= 1'b1;
					default: begin
						oe_q    <= 1'b0;
						state_q <= H_IDLE;
					end
					endcase
				end
			end
			H_BYTE: begin
				if (tick) begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
					2'h0: begin
						// Data set a quarter after SCL fell
						if (bit_q == BITS_PER_BYTE) begin
							oe_q <= rd_q & ~nack_q;
						end else begin
							oe_q <= ~rd_q & ~sh_q[DATA_W-1];
						end
					end
					2'h1: scl_q <= 1'b1;
					2'h2: begin
						if (bit_q == BITS_PER_BYTE) begin
							ack_in_q <= sda_in_q;
						end else begin
							sh_q <= {sh_q[DATA_W-2:0], sda_in_q};
						end
					end
					default: begin
						scl_q <= 1'b0;
						bit_q <= bit_q + 4'h1;
						if (bit_q == BITS_PER_BYTE) begin
							oe_q        <= 1'b0;
							state_q     <= H_IDLE;
							rsp_valid_o <= 1'b1;
							rsp_data_o  <= sh_q;
							rsp_nack_o  <= ack_in_q;
						end
					end
					endcase
				end
			end
			default: state_q <= H_IDLE;
			endcase
		end
	end

	assign bus.scl      = scl_q;
	assign bus.sda_h_o  = 1'b0;
	assign bus.sda_h_oe = oe_q;

endmodule

// ### sim/twct_asserts.sv
/*
 Checker for the two-wire link: watches the interface lines and the address pins only.
 Assumes SCL is made from clk_sys_i and the lines settle between edges.
*/
`timescale 1ns/1ps
module twct_asserts
	import twct_pkg::*;
(
	input wire logic              clk_sys_i,
	input wire logic              rst_n_i,
	input wire logic              scl,
	input wire logic              sda,
	input wire logic              sda_h_o,
	input wire logic              sda_h_oe,
	input wire logic              sda_d_o,
	input wire logic              sda_d_oe,
	input wire logic [ADDR_W-1:0] dev_addr_i
);
	logic       scl_q;
	logic       sda_q;
	logic       act_q;
	logic       first_q;
	logic       sel_q;
	logic       rw_q;
	logic       done_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [5:0] fall_q;
	wire start_w = scl & scl_q & sda_q & ~sda;
	wire stop_w  = scl & scl_q & ~sda_q & sda;
	wire rise_w  = scl & ~scl_q;
	wire ack_w   = rise_w & (bit_q == 4'h8);

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	always_ff @(posedge clk_sys_i) begin
		scl_q <= rst_n_i ? scl : 1'b1;
		sda_q <= rst_n_i ? sda : 1'b1;
	end

	// Frame tracking from raw lines, independent of the target's filter
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || stop_w) begin
			act_q   <= 1'b0;
			first_q <= 1'b1;
			sel_q   <= 1'b0;
			done_q  <= 1'b0;
			bit_q   <= 4'h0;
		end else if (start_w) begin
			act_q   <= 1'b1;
			first_q <= 1'b1;
			sel_q   <= 1'b0;
			done_q  <= 1'b0;
			bit_q   <= 4'h0;
		end else if (ack_w) begin
			bit_q   <= 4'h0;
			first_q <= 1'b0;
			if (first_q) begin
				sel_q <= (sh_q[7:1] == dev_addr_i);
				rw_q  <= sh_q[0];
			end else if (rw_q && sda) begin
				done_q <= 1'b1;
			end
		end else if (rise_w) begin
			bit_q <= bit_q + 4'h1;
			sh_q  <= {sh_q[6:0], sda};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			fall_q <= 6'h3F;
		else if (scl_q && !scl)
			fall_q <= 6'h00;
		else if (fall_q != 6'h3F)
			fall_q <= fall_q + 6'h01;
	end

	ack_addr_a: assert property (ack_w && first_q |->
		sda_d_oe == (sh_q[7:1] == dev_addr_i)) else $error("address ack wrong");
	addr_silent_a: assert property ((!act_q || !sel_q) &&
		!(first_q && bit_q == 4'h8) |-> !sda_d_oe) else $error("not silent");
	wr_ack_a: assert property (ack_w && !first_q && sel_q && !rw_q
		|-> sda_d_oe) else $error("write byte not acked");
	rd_data_a: assert property (rise_w && sel_q && rw_q && !first_q
		&& !done_q && bit_q < 4'h8 |-> sda_d_oe != sda) else $error("read bit");
	hold_high_a: assert property (scl && scl_q |-> $stable(sda_d_oe))
		else $error("target moved sda while scl high");
	change_delay_a: assert property ($changed(sda_d_oe) |->
		!scl && fall_q >= 6'd24) else $error("sda change too early");
	stop_idle_a: assert property (stop_w |=>
		(scl && !sda_d_oe) [*8]) else $error("bus not idle after stop");
	open_drain_a: assert property (!sda_d_o && !sda_h_o)
		else $error("sda driven high");
	// Host owns the ninth bit of every read byte
	rd_release_a: assert property (ack_w && sel_q && rw_q && !first_q
		|-> !sda_d_oe) else $error("target held sda in host ack");
endmodule

// ### sim/testbench.sv
/*
 Testbench: host and target joined by one link, register file modelled here.
 Assumes the design files and twct_pkg are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench
	import twct_pkg::*;
;
	logic              clk_sys_i;
	logic              clk_link_i;
	logic              rst_n_i;
	logic              cmd_valid_i;
	logic              cmd_ready_o;
	twct_op_t          cmd_op_i;
	logic [DATA_W-1:0] cmd_data_i;
	logic              cmd_nack_i;
	logic              rsp_valid_o;
	logic [DATA_W-1:0] rsp_data_o;
	logic              rsp_nack_o;
	logic              busy_o;
	logic [ADDR_W-1:0] dev_addr_i;
	logic              cfg_wr_o;
	logic              cfg_rd_o;
	logic [DATA_W-1:0] cfg_addr_o;
	logic [DATA_W-1:0] cfg_wdata_o;
	logic [DATA_W-1:0] cfg_rdata_i;
	logic [7:0]        mem [256];
	logic [7:0]        shadow [256];
	logic [7:0]        idx;
	logic [7:0]        d;
	int                mismatches;
	int                check_count;
	int                wr_count;
	int                w0;

	twct_link_if link();
	twct_host i_twct_host(.clk_sys_i, .rst_n_i, .bus(link), .cmd_valid_i,
		.cmd_ready_o, .cmd_op_i, .cmd_data_i, .cmd_nack_i, .rsp_valid_o,
		.rsp_data_o, .rsp_nack_o, .busy_o);
	twct_target i_twct_target(.clk_sys_i, .rst_n_i, .clk_link_i,
		.bus(link), .dev_addr_i, .cfg_wr_o, .cfg_rd_o, .cfg_addr_o,
		.cfg_wdata_o, .cfg_rdata_i);
	twct_asserts i_twct_asserts(.clk_sys_i, .rst_n_i, .scl(link.scl),
		.sda(link.sda), .sda_h_o(link.sda_h_o), .sda_h_oe(link.sda_h_oe),
		.sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe), .dev_addr_i);

	// Register file answers combinationally, as the target expects
	assign cfg_rdata_i = mem[cfg_addr_o];
	always @(posedge clk_sys_i) begin
		if (cfg_wr_o) begin
			mem[cfg_addr_o] <= cfg_wdata_o;
			wr_count++;
		end
	end

	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	// Free-running crystal, phase unrelated to the system clock
	initial begin
		clk_link_i = 1'b0;
		#7.3;
		forever #62.5 clk_link_i = ~clk_link_i;
	end

	function automatic logic [7:0] addr_byte(input logic [6:0] a,
		input logic rw);
		return {a, rw};
	endfunction

	function automatic logic [7:0] init_val(input int i);
		return 8'(i * 7 + 31);
	endfunction

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmd(input twct_op_t op, input logic [7:0] dat,
		input logic nk);
		int n;
		n = 0;
		@(negedge clk_sys_i);
		while (cmd_ready_o !== 1'b1 && n < 3000) begin
			@(negedge clk_sys_i);
			n++;
		end
		// A host that never frees up is a failure, not a skip
		if (n >= 3000)
			mismatches++;
		cmd_valid_i = 1'b1;
		cmd_op_i    = op;
		cmd_data_i  = dat;
		cmd_nack_i  = nk;
		@(negedge clk_sys_i);
		cmd_valid_i = 1'b0;
		if (op == OP_WRITE || op == OP_READ) begin
			n = 0;
			while (rsp_valid_o !== 1'b1 && n < 2500) begin
				@(negedge clk_sys_i);
				n++;
			end
			`CHK(rsp_valid_o, 1'b1)
		end
	endtask

	initial begin
		cmd_valid_i = 1'b0;
		cmd_op_i    = OP_START;
		cmd_data_i  = 8'h00;
		cmd_nack_i  = 1'b0;
		dev_addr_i  = 7'h00;
		rst_n_i     = 1'b0;
		mismatches  = 0;
		check_count = 0;
		wr_count    = 0;
		for (int i = 0; i < 256; i++) begin
			mem[i]    = init_val(i);
			shadow[i] = init_val(i);
		end
		void'($urandom(66));
		dev_addr_i = 7'($urandom);
		// Longer than 25 cycles: the link domain needs five crystal edges
		repeat (30) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		repeat (40) @(negedge clk_sys_i);
		`CHK({link.scl, link.sda, link.sda_d_oe, busy_o}, 4'hC)
		for (int t = 0; t < 2; t++) begin
			idx = (t == 0) ? 8'hFE : 8'($urandom);
			w0 = wr_count;
			cmd(OP_START, 8'h00, 1'b0);
			cmd(OP_WRITE, addr_byte(dev_addr_i, 1'b0), 1'b0);
			`CHK(rsp_nack_o, 1'b0)
			cmd(OP_WRITE, idx, 1'b0);
			`CHK(rsp_nack_o, 1'b0)
			for (int k = 0; k < 3; k++) begin
				d = 8'($urandom);
				shadow[8'(idx + 8'(k))] = d;
				cmd(OP_WRITE, d, 1'b0);
				`CHK(rsp_nack_o, 1'b0)
			end
			cmd(OP_STOP, 8'h00, 1'b0);
			repeat (4 * QTR_CYC) @(negedge clk_sys_i);
			`CHK(wr_count - w0, 3)
		end
		w0 = wr_count;
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, addr_byte(dev_addr_i ^ 7'h01, 1'b0), 1'b0);
		`CHK(rsp_nack_o, 1'b1)
		cmd(OP_WRITE, 8'h00, 1'b0);
		`CHK(rsp_nack_o, 1'b1)
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, addr_byte(dev_addr_i, 1'b0), 1'b0);
		cmd(OP_WRITE, 8'h00, 1'b0);
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, addr_byte(dev_addr_i, 1'b1), 1'b0);
		`CHK(rsp_nack_o, 1'b0)
		for (int k = 0; k < 28; k++) begin
			cmd(OP_READ, 8'($urandom), k == 27);
			`CHK(rsp_data_o, shadow[k])
		end
		cmd(OP_STOP, 8'h00, 1'b0);
		repeat (4 * QTR_CYC) @(negedge clk_sys_i);
		`CHK(wr_count - w0, 0)
		// Every write landed at the pointer, wrap included
		for (int i = 0; i < 256; i++) begin
			`CHK(mem[i], shadow[i])
		end
		final_report();
	end

	// Roughly 80k cycles of traffic; limit stays below 100k
	initial begin
		repeat (95000) @(posedge clk_sys_i);
		mismatches++;
		final_report();
	end
endmodule
